// ### common/dbgp_pkg.sv
// Constants for the dual branch 32-pin general purpose port.
// Assumes one 200 MHz clock, a synchronous reset, and address buses
// that present full byte addresses.
//
// Behaviour
// - System flag picks which branch drives pins
// - Branches keep separate state, never cross-visible
// - Legacy registers accept full word accesses only
// - Fast registers honour byte and half-word lanes
// - Register bit n maps to pin n
// - Legacy pin read shows live GPIO levels, alternate function pins read zero
// - Legacy set write drives ones high
// - Legacy clear write drives ones low
// - Each branch has direction register, reset zero
// - Direction bit acts only in GPIO mode
// - Fast mask active low, gates pin accesses
// - Fast pin read shows level except analog
// - Fast pin read filtered by the mask
// - Fast pin write loads unmasked outputs
// - Fast set write drives unmasked ones high
// - Fast set read returns output latch
// - Fast clear write drives unmasked ones low
// - Direction zero input, one output
// - All pins are inputs after reset
// - Alternate function sets its own direction
package dbgp_pkg;
  // Port geometry
  localparam int DBGP_PINS = 32;
  localparam int DBGP_LANES = 4;
  localparam logic [3:0] DBGP_BE_WORD = 4'hf;
  // Legacy branch byte addresses
  localparam logic [31:0] DBGP_LEG_PIN = 32'he002_8000;
  localparam logic [31:0] DBGP_LEG_SET = 32'he002_8004;
  localparam logic [31:0] DBGP_LEG_DIR = 32'he002_8008;
  localparam logic [31:0] DBGP_LEG_CLR = 32'he002_800c;
  // Fast branch byte addresses
  localparam logic [31:0] DBGP_FST_DIR = 32'h3fff_c000;
  localparam logic [31:0] DBGP_FST_MASK = 32'h3fff_c010;
  localparam logic [31:0] DBGP_FST_PIN = 32'h3fff_c014;
  localparam logic [31:0] DBGP_FST_SET = 32'h3fff_c018;
  localparam logic [31:0] DBGP_FST_CLR = 32'h3fff_c01c;
  // Word alignment of an address
  localparam logic [31:0] DBGP_WORD_MASK = 32'hffff_fffc;
  // Reset and fixed read values
  localparam logic [31:0] DBGP_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] DBGP_RD_NONE = 32'h0000_0000;
endpackage

// ### rtl/dbgp_sync.sv
// Two flip-flop synchroniser for the pin inputs.
// Assumes the inputs are asynchronous to the clock.
`timescale 1ns/100ps
module dbgp_sync
  import dbgp_pkg::*;
(
  input wire logic REF_CLK_I, // Port clock
  input wire logic RST_I, // Synchronous reset, high
  input wire logic [DBGP_PINS-1:0] async_i, // Raw pin levels
  output logic [DBGP_PINS-1:0] sync_o // Synchronised levels
);
  logic [DBGP_PINS-1:0] stage1_r; // First stage, read only by stage two
  logic [DBGP_PINS-1:0] stage2_r; // Second stage

  ////////////////////////////////////////////////////////////////////////////
  // Two stages, first one feeds only the second
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      stage1_r <= DBGP_RST_ZERO;
      stage2_r <= DBGP_RST_ZERO;
    end
    else
    begin
      stage1_r <= async_i;
      stage2_r <= stage1_r;
    end
  end

  assign sync_o = stage2_r;
endmodule

// ### rtl/dbgp_port.sv
// Dual branch 32-pin general purpose port: legacy word-only register
// set and fast register set with byte lanes and an active-low mask.
// Assumes both register buses and the alternate function inputs run on
// REF_CLK_I; only the pin inputs are asynchronous.
`timescale 1ns/100ps
module dbgp_port
  import dbgp_pkg::*;
(
  input wire logic REF_CLK_I, // 200 MHz clock
  input wire logic RST_I, // Synchronous reset, high
  input wire logic SYS_FAST_SEL_I, // Flag: 1 fast branch, 0 legacy
  input wire logic LEG_SEL_I, // Legacy access request
  input wire logic LEG_WR_I, // Legacy write when high
  input wire logic [31:0] LEG_ADDR_I, // Legacy byte address
  input wire logic [3:0] LEG_BE_I, // Legacy byte enables
  input wire logic [31:0] LEG_WDATA_I, // Legacy write data
  output logic [31:0] LEG_RDATA_O, // Legacy read data
  output logic LEG_ACK_O, // Legacy access done
  output logic LEG_ERR_O, // Legacy narrow access refused
  input wire logic FST_SEL_I, // Fast access request
  input wire logic FST_WR_I, // Fast write when high
  input wire logic [31:0] FST_ADDR_I, // Fast byte address
  input wire logic [3:0] FST_BE_I, // Fast byte enables
  input wire logic [31:0] FST_WDATA_I, // Fast write data
  output logic [31:0] FST_RDATA_O, // Fast read data
  output logic FST_ACK_O, // Fast access done
  input wire logic [31:0] PIN_ALT_SEL_I, // Pin uses alternate function
  input wire logic [31:0] PIN_ANALOG_I, // Pin is an analog input
  input wire logic [31:0] ALT_OUT_I, // Alternate function output level
  input wire logic [31:0] ALT_OE_I, // Alternate function drive enable
  input wire logic [31:0] GPIO_IN_I, // Pin levels, asynchronous
  output logic [31:0] GPIO_OUT_O, // Pin output levels
  output logic [31:0] GPIO_OE_O // Pin drive enables, high drives
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte enables to a 32-bit lane mask
  function automatic logic [31:0] lane_bits(input logic [3:0] be);
    logic [31:0] m;
    m = DBGP_RST_ZERO;
    for (int i = 0; i < DBGP_LANES; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Replace the enabled bits of old with new
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] en);
    return (old_v & ~en) | (new_v & en);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [31:0] pin_sync; // Synchronised pin levels
  logic [31:0] leg_out_r, leg_out_nxt; // Legacy output latch
  logic [31:0] leg_dir_r, leg_dir_nxt; // Legacy direction
  logic [31:0] fst_out_r, fst_out_nxt; // Fast output latch
  logic [31:0] fst_dir_r, fst_dir_nxt; // Fast direction
  logic [31:0] fst_mask_r, fst_mask_nxt; // Fast mask, active low
  logic [31:0] leg_rdata_r, leg_rdata_nxt; // Legacy read data
  logic [31:0] fst_rdata_r, fst_rdata_nxt; // Fast read data
  logic leg_ack_r, leg_ack_nxt; // Legacy acknowledge
  logic leg_err_r, leg_err_nxt; // Legacy refusal flag
  logic fst_ack_r, fst_ack_nxt; // Fast acknowledge
  logic [31:0] pin_out_r, pin_out_nxt; // Registered pin levels
  logic [31:0] pin_oe_r, pin_oe_nxt; // Registered pin enables
  logic [31:0] leg_word; // Legacy word address
  logic [31:0] fst_word; // Fast word address
  logic leg_ok; // Legacy full-word access
  logic [31:0] fst_en; // Fast lanes and unmasked bits

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser

  dbgp_sync u_sync (
    .REF_CLK_I(REF_CLK_I),
    .RST_I(RST_I),
    .async_i(GPIO_IN_I),
    .sync_o(pin_sync)
  );

  assign leg_word = LEG_ADDR_I & DBGP_WORD_MASK;
  assign fst_word = FST_ADDR_I & DBGP_WORD_MASK;
  assign leg_ok = (LEG_BE_I == DBGP_BE_WORD);
  assign fst_en = lane_bits(FST_BE_I) & ~fst_mask_r;

  ////////////////////////////////////////////////////////////////////////////
  // Legacy branch: next state and read data
  always_comb
  begin
    leg_out_nxt = leg_out_r;
    leg_dir_nxt = leg_dir_r;
    leg_rdata_nxt = leg_rdata_r;
    leg_ack_nxt = LEG_SEL_I;
    leg_err_nxt = LEG_SEL_I && !leg_ok;
    if (LEG_SEL_I && leg_ok && LEG_WR_I)
    begin
      if (leg_word == DBGP_LEG_PIN)
      begin
        leg_out_nxt = LEG_WDATA_I;
      end
      else if (leg_word == DBGP_LEG_SET)
      begin
        leg_out_nxt = leg_out_r | LEG_WDATA_I;
      end
      else if (leg_word == DBGP_LEG_DIR)
      begin
        leg_dir_nxt = LEG_WDATA_I;
      end
      else if (leg_word == DBGP_LEG_CLR)
      begin
        leg_out_nxt = leg_out_r & ~LEG_WDATA_I;
      end
    end
    if (LEG_SEL_I && !LEG_WR_I)
    begin
      if (!leg_ok)
      begin
        leg_rdata_nxt = DBGP_RD_NONE;
      end
      else if (leg_word == DBGP_LEG_PIN)
      begin
        leg_rdata_nxt = pin_sync & ~PIN_ALT_SEL_I;
      end
      else if (leg_word == DBGP_LEG_SET)
      begin
        leg_rdata_nxt = leg_out_r;
      end
      else if (leg_word == DBGP_LEG_DIR)
      begin
        leg_rdata_nxt = leg_dir_r;
      end
      else
      begin
        leg_rdata_nxt = DBGP_RD_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast branch: next state and read data
  always_comb
  begin
    fst_out_nxt = fst_out_r;
    fst_dir_nxt = fst_dir_r;
    fst_mask_nxt = fst_mask_r;
    fst_rdata_nxt = fst_rdata_r;
    fst_ack_nxt = FST_SEL_I;
    if (FST_SEL_I && FST_WR_I)
    begin
      if (fst_word == DBGP_FST_DIR)
      begin
        fst_dir_nxt = merge(fst_dir_r, FST_WDATA_I, lane_bits(FST_BE_I));
      end
      else if (fst_word == DBGP_FST_MASK)
      begin
        fst_mask_nxt = merge(fst_mask_r, FST_WDATA_I, lane_bits(FST_BE_I));
      end
      else if (fst_word == DBGP_FST_PIN)
      begin
        fst_out_nxt = merge(fst_out_r, FST_WDATA_I, fst_en);
      end
      else if (fst_word == DBGP_FST_SET)
      begin
        fst_out_nxt = fst_out_r | (FST_WDATA_I & fst_en);
      end
      else if (fst_word == DBGP_FST_CLR)
      begin
        fst_out_nxt = fst_out_r & ~(FST_WDATA_I & fst_en);
      end
    end
    if (FST_SEL_I && !FST_WR_I)
    begin
      if (fst_word == DBGP_FST_DIR)
      begin
        fst_rdata_nxt = fst_dir_r;
      end
      else if (fst_word == DBGP_FST_MASK)
      begin
        fst_rdata_nxt = fst_mask_r;
      end
      else if (fst_word == DBGP_FST_PIN)
      begin
        fst_rdata_nxt = pin_sync & ~PIN_ANALOG_I & ~fst_mask_r;
      end
      else if (fst_word == DBGP_FST_SET)
      begin
        fst_rdata_nxt = fst_out_r;
      end
      else
      begin
        fst_rdata_nxt = DBGP_RD_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: branch select and alternate functions
  always_comb
  begin
    if (SYS_FAST_SEL_I)
    begin
      pin_out_nxt = fst_out_r;
      pin_oe_nxt = fst_dir_r;
    end
    else
    begin
      pin_out_nxt = leg_out_r;
      pin_oe_nxt = leg_dir_r;
    end
    pin_out_nxt = merge(pin_out_nxt, ALT_OUT_I, PIN_ALT_SEL_I);
    pin_oe_nxt = merge(pin_oe_nxt, ALT_OE_I, PIN_ALT_SEL_I);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      leg_out_r <= DBGP_RST_ZERO;
      leg_dir_r <= DBGP_RST_ZERO;
      fst_out_r <= DBGP_RST_ZERO;
      fst_dir_r <= DBGP_RST_ZERO;
      fst_mask_r <= DBGP_RST_ZERO;
      leg_rdata_r <= DBGP_RST_ZERO;
      fst_rdata_r <= DBGP_RST_ZERO;
      leg_ack_r <= 1'b0;
      leg_err_r <= 1'b0;
      fst_ack_r <= 1'b0;
      pin_out_r <= DBGP_RST_ZERO;
      pin_oe_r <= DBGP_RST_ZERO;
    end
    else
    begin
      leg_out_r <= leg_out_nxt;
      leg_dir_r <= leg_dir_nxt;
      fst_out_r <= fst_out_nxt;
      fst_dir_r <= fst_dir_nxt;
      fst_mask_r <= fst_mask_nxt;
      leg_rdata_r <= leg_rdata_nxt;
      fst_rdata_r <= fst_rdata_nxt;
      leg_ack_r <= leg_ack_nxt;
      leg_err_r <= leg_err_nxt;
      fst_ack_r <= fst_ack_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign LEG_RDATA_O = leg_rdata_r;
  assign LEG_ACK_O = leg_ack_r;
  assign LEG_ERR_O = leg_err_r;
  assign FST_RDATA_O = fst_rdata_r;
  assign FST_ACK_O = fst_ack_r;
  assign GPIO_OUT_O = pin_out_r;
  assign GPIO_OE_O = pin_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  leg_set_high_a: assert property (
    LEG_SEL_I && LEG_WR_I && leg_ok && leg_word == DBGP_LEG_SET
    |=> (leg_out_r & $past(LEG_WDATA_I)) == $past(LEG_WDATA_I))
    else $error("legacy set did not raise bits");

  leg_clr_low_a: assert property (
    LEG_SEL_I && LEG_WR_I && leg_ok && leg_word == DBGP_LEG_CLR
    |=> (leg_out_r & $past(LEG_WDATA_I)) == DBGP_RST_ZERO)
    else $error("legacy clear did not lower bits");

  leg_narrow_refused_a: assert property (
    LEG_SEL_I && !leg_ok
    |=> LEG_ERR_O && $stable(leg_out_r) && $stable(leg_dir_r))
    else $error("narrow legacy access changed state");

  fst_mask_hold_a: assert property (
    FST_SEL_I && FST_WR_I && fst_word == DBGP_FST_PIN
    |=> ((fst_out_r ^ $past(fst_out_r)) & $past(fst_mask_r)) == DBGP_RST_ZERO)
    else $error("masked fast bit changed");

  fst_lane_hold_a: assert property (
    FST_SEL_I && FST_WR_I && fst_word == DBGP_FST_DIR
    |=> ((fst_dir_r ^ $past(fst_dir_r)) & ~lane_bits($past(FST_BE_I)))
        == DBGP_RST_ZERO)
    else $error("fast write touched a disabled lane");

  branch_isolate_a: assert property (
    FST_SEL_I && !LEG_SEL_I |=> $stable(leg_out_r) && $stable(leg_dir_r))
    else $error("fast access leaked into legacy state");
  fst_read_mask_a: assert property (
    FST_SEL_I && !FST_WR_I && fst_word == DBGP_FST_PIN
    |=> FST_ACK_O && (FST_RDATA_O & $past(fst_mask_r)) == DBGP_RD_NONE)
    else $error("fast pin read shows masked bit");

  pin_dir_select_a: assert property (
    ##1 ((GPIO_OE_O ^ ($past(SYS_FAST_SEL_I) ? $past(fst_dir_r)
                                              : $past(leg_dir_r)))
         & ~$past(PIN_ALT_SEL_I)) == DBGP_RST_ZERO)
    else $error("pin enables not from selected branch");

  reset_inputs_a: assert property (@(posedge REF_CLK_I) disable iff (1'b0)
    RST_I |=> GPIO_OE_O == DBGP_RST_ZERO && fst_dir_r == DBGP_RST_ZERO
              && leg_dir_r == DBGP_RST_ZERO)
    else $error("pins not inputs after reset");

  leg_set_cov: cover property (LEG_SEL_I && LEG_WR_I && leg_word == DBGP_LEG_SET);
  fst_masked_cov: cover property (FST_SEL_I && FST_WR_I && fst_mask_r != DBGP_RST_ZERO);
  sel_switch_cov: cover property ($changed(SYS_FAST_SEL_I));
  narrow_cov: cover property (FST_SEL_I && FST_BE_I != DBGP_BE_WORD);
endmodule

// ### bench/dbgp_pin_model.sv
// Pin-side model: the outside circuits wired to the 32 port pins.
// Assumes the port drives a pin only where its drive enable is high.
`timescale 1ns/100ps
module dbgp_pin_model
(
  input wire logic [31:0] out_i, // Port output levels
  input wire logic [31:0] oe_i, // Port drive enables
  input wire logic [31:0] ext_i, // Levels forced by outside circuits
  output logic [31:0] pin_o // Resolved pin levels
);
  // A driven pin follows the port, a released one the outside circuit
  assign pin_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule

// ### bench/dbgp_tb.sv
// Self-checking bench for the dual branch port: both register buses,
// branch select, mask, byte lanes, analog and alternate function pins.
// Assumes the port, its package and the pin model are compiled first.
`timescale 1ns/100ps
module tb;
  import dbgp_pkg::*;
  logic clk = 1'b0; // Port clock
  logic rst = 1'b1; // Reset, high
  logic fsw = 1'b0; // Branch select
  logic lsel = 1'b0, lwr = 1'b0, fsel = 1'b0, fwr = 1'b0; // Bus strobes
  logic [31:0] laddr = '0, lwd = '0, faddr = '0, fwd = '0; // Bus data
  logic [3:0] lbe = 4'h0, fbe = 4'h0; // Byte enables
  logic [31:0] lrd, frd, alt_sel = '0, ana = '0, alt_out = '0, alt_oe = '0;
  logic [31:0] ext = 32'h1234_5678, pins, pout, poe; // Pin side
  logic lack, lerr, fack; // Bus answers
  int errors = 0;
  int cmp_count = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  dbgp_port dbgp_port_i (.REF_CLK_I(clk), .RST_I(rst), .SYS_FAST_SEL_I(fsw),
    .LEG_SEL_I(lsel), .LEG_WR_I(lwr), .LEG_ADDR_I(laddr), .LEG_BE_I(lbe),
    .LEG_WDATA_I(lwd), .LEG_RDATA_O(lrd), .LEG_ACK_O(lack), .LEG_ERR_O(lerr),
    .FST_SEL_I(fsel), .FST_WR_I(fwr), .FST_ADDR_I(faddr), .FST_BE_I(fbe),
    .FST_WDATA_I(fwd), .FST_RDATA_O(frd), .FST_ACK_O(fack),
    .PIN_ALT_SEL_I(alt_sel), .PIN_ANALOG_I(ana), .ALT_OUT_I(alt_out),
    .ALT_OE_I(alt_oe), .GPIO_IN_I(pins), .GPIO_OUT_O(pout), .GPIO_OE_O(poe));
  dbgp_pin_model dbgp_pin_model_i (.out_i(pout), .oe_i(poe), .ext_i(ext),
    .pin_o(pins));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and run end
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compare one value, four-state exact
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One access: strobe for one cycle, answer taken at the ack cycle
  task automatic acc(input logic f, input logic w, input logic [31:0] a,
    input logic [3:0] be, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(negedge clk);
    if (f)
      {fsel, fwr, faddr, fbe, fwd} = {1'b1, w, a, be, d};
    else
      {lsel, lwr, laddr, lbe, lwd} = {1'b1, w, a, be, d};
    @(negedge clk);
    fsel = 1'b0;
    lsel = 1'b0;
    // Bounded wait for the answer pulse
    while ((f ? fack : lack) !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    q = f ? frd : lrd;
    e = lerr;
    if (n == 4)
    begin
      errors++;
      $display("ERROR ack expected 1 seen timeout");
      end_sim();
    end
  endtask

  task automatic wr(input int f, input logic [31:0] a, input logic [3:0] be,
    input logic [31:0] d);
    logic [31:0] q;
    logic e;
    acc(f != 0, 1'b1, a, be, d, q, e);
  endtask

  task automatic rd(input int f, input logic [31:0] a, input logic [31:0] x,
    input string nm);
    logic [31:0] q;
    logic e;
    acc(f != 0, 1'b0, a, DBGP_BE_WORD, '0, q, e);
    chk(nm, x, q);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset values and all pins released
  task automatic t_reset();
    chk("oe", 32'h0000_0000, poe);
    rd(0, DBGP_LEG_DIR, 32'h0000_0000, "leg_dir");
    rd(0, DBGP_LEG_SET, 32'h0000_0000, "leg_set");
    rd(1, DBGP_FST_DIR, 32'h0000_0000, "fst_dir");
    rd(1, DBGP_FST_MASK, 32'h0000_0000, "fst_mask");
    rd(1, DBGP_FST_SET, 32'h0000_0000, "fst_set");
    $display("Test reset done");
  endtask

  // Legacy branch: direction, set, clear, live pin read, narrow refusal
  task automatic t_legacy();
    logic [31:0] q;
    logic e;
    wr(0, DBGP_LEG_DIR, DBGP_BE_WORD, 32'hffff_0000);
    wr(0, DBGP_LEG_SET, DBGP_BE_WORD, 32'ha5a5_0000);
    wr(0, DBGP_LEG_CLR, DBGP_BE_WORD, 32'h0500_0000);
    rd(0, DBGP_LEG_SET, 32'ha0a5_0000, "leg_set");
    rd(0, DBGP_LEG_CLR, 32'h0000_0000, "leg_clr");
    repeat (3) @(negedge clk);
    chk("oe", 32'hffff_0000, poe);
    chk("out", 32'ha0a5_0000, pout & poe);
    rd(0, DBGP_LEG_PIN, 32'ha0a5_5678, "leg_pin");
    acc(1'b0, 1'b1, DBGP_LEG_SET, 4'h1, 32'h0000_00ff, q, e);
    chk("leg_err", 32'h1, {31'h0, e});
    rd(0, DBGP_LEG_SET, 32'ha0a5_0000, "leg_set");
    rd(0, 32'he002_8010, 32'h0000_0000, "leg_unmapped");
    $display("Test legacy done");
  endtask

  // Fast branch: lanes, mask on pin/set writes and pin reads, clear write on unmasked bits only
  task automatic t_fast();
    fsw = 1'b1;
    repeat (3) @(negedge clk);
    chk("oe", 32'h0000_0000, poe);
    wr(1, DBGP_FST_DIR, 4'h1, 32'hffff_ffff);
    rd(1, DBGP_FST_DIR, 32'h0000_00ff, "fst_dir");
    wr(1, DBGP_FST_MASK, DBGP_BE_WORD, 32'h0000_000f);
    wr(1, DBGP_FST_PIN, DBGP_BE_WORD, 32'hffff_ffff);
    rd(1, DBGP_FST_SET, 32'hffff_fff0, "fst_set");
    wr(1, DBGP_FST_CLR, DBGP_BE_WORD, 32'h0000_00f0);
    rd(1, DBGP_FST_SET, 32'hffff_ff00, "fst_set");
    wr(1, DBGP_FST_SET, DBGP_BE_WORD, 32'h0000_003c);
    rd(1, DBGP_FST_SET, 32'hffff_ff30, "fst_set");
    wr(0, DBGP_LEG_SET, DBGP_BE_WORD, 32'h0000_0001);
    ana = 32'h0004_0000;
    repeat (3) @(negedge clk);
    chk("oe", 32'h0000_00ff, poe);
    chk("out", 32'h0000_0030, pout & poe);
    // Mask a pin that reads high so the filter can be seen
    wr(1, DBGP_FST_MASK, DBGP_BE_WORD, 32'h0000_0010);
    rd(1, DBGP_FST_PIN, 32'h1230_5620, "fst_pin");
    rd(0, DBGP_LEG_SET, 32'ha0a5_0001, "leg_set");
    rd(0, DBGP_LEG_DIR, 32'hffff_0000, "leg_dir");
    $display("Test fast done");
  endtask

  // Alternate function takes over output and direction of its pins
  task automatic t_alt();
    alt_sel = 32'h0000_0003;
    alt_out = 32'h0000_0001;
    alt_oe = 32'h0000_0001;
    repeat (3) @(negedge clk);
    chk("oe", 32'h0000_00fd, poe);
    chk("out", 32'h0000_0031, pout & poe);
    $display("Test alternate done");
  endtask

  // Mid-run reset: pins back to inputs, both branches cleared
  task automatic t_rst2();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("oe", 32'h0000_0000, poe);
    rd(1, DBGP_FST_DIR, 32'h0000_0000, "fst_dir");
    rd(0, DBGP_LEG_DIR, 32'h0000_0000, "leg_dir");
    rd(1, DBGP_FST_MASK, 32'h0000_0000, "fst_mask");
    rd(0, DBGP_LEG_SET, 32'h0000_0000, "leg_set");
    wr(0, DBGP_LEG_PIN, DBGP_BE_WORD, 32'h0000_0f0f);
    rd(0, DBGP_LEG_SET, 32'h0000_0f0f, "leg_set");
    rd(1, DBGP_FST_CLR, 32'h0000_0000, "fst_clr");
    chk("oe", 32'h0000_0001, poe);
    $display("Test mid-run reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_legacy();
    t_fast();
    t_alt();
    t_rst2();
    end_sim();
  end
endmodule
